// *** include/fce_pkg.sv ***
// Shared types and constants of the flow-control execute block.
// Assumes the core hands over one decoded flow instruction at a time.
package fce_pkg;

    // ****************************************************************
    // Widths and flag positions
    // ****************************************************************
    localparam int PC_W = 22;
    localparam logic [2:0] FLAG_C = 3'h0;
    localparam logic [2:0] FLAG_Z = 3'h1;
    localparam logic [2:0] FLAG_N = 3'h2;
    localparam logic [2:0] FLAG_V = 3'h3;
    localparam logic [2:0] FLAG_H = 3'h5;
    localparam logic [2:0] FLAG_T = 3'h6;
    localparam logic [2:0] FLAG_I = 3'h7;

    // ****************************************************************
    // Cycle counts and program counter steps
    // ****************************************************************
    localparam logic [2:0] CYC_INDIRECT_CALL   = 3'h2;
    localparam logic [2:0] CYC_EXTENDED_INDIRECT_CALL  = 3'h3;
    localparam logic [2:0] CYC_SEQ     = 3'h1;
    localparam logic [2:0] CYC_TAKEN   = 3'h2;
    localparam logic [2:0] CYC_SKIP1   = 3'h2;
    localparam logic [2:0] CYC_SKIP2   = 3'h3;
    localparam logic [2:0] CYC_IO_XTRA = 3'h1;
    localparam logic [PC_W-1:0] STEP_SEQ   = 22'h000001;
    localparam logic [PC_W-1:0] STEP_SKIP1 = 22'h000002;
    localparam logic [PC_W-1:0] STEP_SKIP2 = 22'h000003;
    localparam logic [5:0] PC_HI_ZERO = 6'h00;
    localparam logic [2:0] CNT_RST = 3'h0;
    localparam logic [PC_W-1:0] PC_RST = 22'h000000;
    localparam logic [5:0] IO_ADDR_RST = 6'h00;

    // ****************************************************************
    // Operations
    // ****************************************************************
    typedef enum logic [4:0] {
        OP_NONE, OP_INDIRECT_CALL, OP_EXT_INDIRECT_CALL,
        OP_COMPARE_SKIP_EQUAL, OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET,
        OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET,
        OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR,
        OP_BRANCH_EQUAL, OP_BRANCH_NOT_EQUAL,
        OP_BRANCH_CARRY_SET, OP_BRANCH_CARRY_CLEAR,
        OP_BRANCH_SAME_HIGHER, OP_BRANCH_LOWER,
        OP_BRANCH_MINUS, OP_BRANCH_PLUS,
        OP_BRANCH_GE_SIGNED, OP_BRANCH_LT_SIGNED,
        OP_BRANCH_HALFCARRY_SET, OP_BRANCH_HALFCARRY_CLEAR,
        OP_BRANCH_TFLAG_SET, OP_BRANCH_TFLAG_CLEAR,
        OP_BRANCH_OVERFLOW_SET, OP_BRANCH_OVERFLOW_CLEAR,
        OP_BRANCH_IRQ_ENABLED, OP_BRANCH_IRQ_DISABLED
    } fce_op_t;

    // One decoded instruction.
    typedef struct packed {
        fce_op_t         op;
        logic [2:0]      flag_sel;
        logic [2:0]      bit_sel;
        logic [6:0]      offset;
        logic [5:0]      io_addr;
        logic            next_two_word;
    } fce_req_t;

    // Core state sampled with the instruction.
    typedef struct packed {
        logic [PC_W-1:0] pc;
        logic [15:0]     z_ptr;
        logic [5:0]      extended_indirect_reg;
        logic [7:0]      status_flags;
        logic [7:0]      rd_val;
        logic [7:0]      rr_val;
    } fce_ctx_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_IO   = 2'b01,
        ST_WAIT = 2'b11
    } fce_state_t;

endpackage

// *** src/fce_exec.sv ***
// Flow-control execute unit: calls, skips and conditional branches.
// Assumes the core holds req and ctx stable while issue_valid is high
// and answers an I/O read combinationally in the cycle io_rd_en is high.
//
// Behaviour
// RULE1: Indirect call loads PC low from Z, clears PC high, two or three cycles.
// RULE2: Extended indirect call loads PC high from extended register, three cycles.
// RULE3: Compare-skip skips the next instruction when both registers are equal.
// RULE4: Register bit clear skip skips when the selected bit is zero.
// RULE5: Register bit set skip skips when the selected bit is one.
// RULE6: I/O bit clear skip skips on zero, taking two to four cycles.
// RULE7: I/O bit set skip skips on one, taking two to four cycles.
// RULE8: Generic flag branches test a selected status bit, target PC+k+1.
// RULE9: Equal branches on zero flag one, not-equal on zero flag zero.
// RULE10: Carry set and lower on carry one; clear and same-higher on zero.
// RULE11: Minus on negative one, plus on negative zero.
// RULE12: Signed branches test negative xor overflow: ge on zero, lt on one.
// RULE13: Half-carry branches test the half-carry flag set or cleared.
// RULE14: Transfer-bit branches test the T flag set or cleared.
// RULE15: Overflow branches test the overflow flag set or cleared.
// RULE16: Interrupt-state branches test the global interrupt enable flag.
// RULE17: A skip adds two over a one-word, three over a two-word instruction.
// RULE18: No flags change; an untaken branch continues at PC+1 after one cycle.
`timescale 1ns/10ps
`default_nettype none

module fce_exec #(
    parameter logic [2:0] INDIRECT_CALL_CYCLES = fce_pkg::CYC_INDIRECT_CALL
) (
    // Clock and reset.
    input  wire logic                    ref_clk,
    input  wire logic                    rstn,
    // Instruction issue.
    input  wire logic                    issue_valid,
    input  wire fce_pkg::fce_req_t       req,
    input  wire fce_pkg::fce_ctx_t       ctx,
    output var  logic                    ready,
    // Program counter answer.
    output var  logic                    done,
    output var  logic [fce_pkg::PC_W-1:0] pc_next,
    // I/O register read port.
    output var  logic                    io_rd_en,
    output var  logic [5:0]              io_addr,
    input  wire logic [7:0]              io_rdata
);

    // ****************************************************************
    // State
    // ****************************************************************
    fce_pkg::fce_state_t          state;
    fce_pkg::fce_state_t          next_state;
    logic [2:0]                   cnt;
    logic [2:0]                   next_cnt;
    logic [fce_pkg::PC_W-1:0]     next_pc_next;
    logic [fce_pkg::PC_W-1:0]     tgt;
    logic [fce_pkg::PC_W-1:0]     next_tgt;
    logic                         next_ready;
    logic                         next_done;
    logic                         next_io_rd_en;
    logic [5:0]                   next_io_addr;
    fce_pkg::fce_req_t            req_q;
    fce_pkg::fce_req_t            next_req_q;
    logic [fce_pkg::PC_W-1:0]     pc_q;
    logic [fce_pkg::PC_W-1:0]     next_pc_q;

    // ****************************************************************
    // Condition and target evaluation
    // ****************************************************************
    logic                         issue;
    logic [7:0]                   sf;
    logic                         br_cond;
    logic                         is_branch;
    logic [fce_pkg::PC_W-1:0]     br_tgt;
    logic [fce_pkg::PC_W-1:0]     seq_tgt;
    logic [fce_pkg::PC_W-1:0]     skip_tgt;
    logic [2:0]                   skip_cyc;
    logic                         io_cond;

    assign issue = issue_valid && ready;
    assign sf    = ctx.status_flags;
    // Relative target with the seven-bit offset sign extended.
    assign br_tgt = ctx.pc + {{15{req.offset[6]}}, req.offset}
                    + fce_pkg::STEP_SEQ;                          // [RULE8]
    assign seq_tgt = ctx.pc + fce_pkg::STEP_SEQ;                  // [RULE18]
    // The skip length follows the size of the instruction skipped.
    assign skip_tgt = ctx.pc + (req.next_two_word ? fce_pkg::STEP_SKIP2
                                                  : fce_pkg::STEP_SKIP1); // [RULE17]
    assign skip_cyc = req.next_two_word ? fce_pkg::CYC_SKIP2
                                        : fce_pkg::CYC_SKIP1;     // [RULE17]
    // The I/O bit is judged against the polarity of the stored op.
    assign io_cond = io_rdata[req_q.bit_sel]
                     == (req_q.op == fce_pkg::OP_SKIP_IO_BIT_SET); // [RULE6] [RULE7]

    // Branch condition for every flag test. Flags are only read here.
    always_comb begin
        is_branch = 1'b1;
        br_cond   = 1'b0;
        case (req.op)
            fce_pkg::OP_BRANCH_FLAG_SET:        br_cond = sf[req.flag_sel];  // [RULE8]
            fce_pkg::OP_BRANCH_FLAG_CLEAR:      br_cond = !sf[req.flag_sel]; // [RULE8]
            fce_pkg::OP_BRANCH_EQUAL:           br_cond = sf[fce_pkg::FLAG_Z];  // [RULE9]
            fce_pkg::OP_BRANCH_NOT_EQUAL:       br_cond = !sf[fce_pkg::FLAG_Z]; // [RULE9]
            fce_pkg::OP_BRANCH_CARRY_SET:       br_cond = sf[fce_pkg::FLAG_C];  // [RULE10]
            fce_pkg::OP_BRANCH_LOWER:           br_cond = sf[fce_pkg::FLAG_C];  // [RULE10]
            fce_pkg::OP_BRANCH_CARRY_CLEAR:     br_cond = !sf[fce_pkg::FLAG_C]; // [RULE10]
            fce_pkg::OP_BRANCH_SAME_HIGHER:     br_cond = !sf[fce_pkg::FLAG_C]; // [RULE10]
            fce_pkg::OP_BRANCH_MINUS:           br_cond = sf[fce_pkg::FLAG_N];  // [RULE11]
            fce_pkg::OP_BRANCH_PLUS:            br_cond = !sf[fce_pkg::FLAG_N]; // [RULE11]
            fce_pkg::OP_BRANCH_GE_SIGNED:
                br_cond = !(sf[fce_pkg::FLAG_N] ^ sf[fce_pkg::FLAG_V]);       // [RULE12]
            fce_pkg::OP_BRANCH_LT_SIGNED:
                br_cond = sf[fce_pkg::FLAG_N] ^ sf[fce_pkg::FLAG_V];          // [RULE12]
            fce_pkg::OP_BRANCH_HALFCARRY_SET:   br_cond = sf[fce_pkg::FLAG_H];  // [RULE13]
            fce_pkg::OP_BRANCH_HALFCARRY_CLEAR: br_cond = !sf[fce_pkg::FLAG_H]; // [RULE13]
            fce_pkg::OP_BRANCH_TFLAG_SET:       br_cond = sf[fce_pkg::FLAG_T];  // [RULE14]
            fce_pkg::OP_BRANCH_TFLAG_CLEAR:     br_cond = !sf[fce_pkg::FLAG_T]; // [RULE14]
            fce_pkg::OP_BRANCH_OVERFLOW_SET:    br_cond = sf[fce_pkg::FLAG_V];  // [RULE15]
            fce_pkg::OP_BRANCH_OVERFLOW_CLEAR:  br_cond = !sf[fce_pkg::FLAG_V]; // [RULE15]
            fce_pkg::OP_BRANCH_IRQ_ENABLED:     br_cond = sf[fce_pkg::FLAG_I];  // [RULE16]
            fce_pkg::OP_BRANCH_IRQ_DISABLED:    br_cond = !sf[fce_pkg::FLAG_I]; // [RULE16]
            default:                            is_branch = 1'b0;
        endcase
    end

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    // An operation of N cycles raises done N-1 edges after the edge that takes it.
    // One-cycle operations answer at once and keep ready high, so a
    // branch stream can issue every cycle.
    always_comb begin
        logic [2:0] cyc;
        logic       go;
        cyc           = fce_pkg::CYC_SEQ;
        go            = 1'b0;
        next_state    = state;
        next_cnt      = cnt;
        next_tgt      = tgt;
        next_pc_next  = pc_next;
        next_ready    = ready;
        next_done     = 1'b0;
        next_io_rd_en = 1'b0;
        next_io_addr  = io_addr;
        next_req_q    = req_q;
        next_pc_q     = pc_q;
        case (state)
            fce_pkg::ST_IDLE: begin
                if (issue) begin
                    go        = 1'b1;
                    next_tgt  = seq_tgt;
                    next_req_q = req;
                    next_pc_q  = ctx.pc;
                    case (req.op)
                        fce_pkg::OP_INDIRECT_CALL: begin
                            next_tgt = {fce_pkg::PC_HI_ZERO, ctx.z_ptr};     // [RULE1]
                            cyc      = INDIRECT_CALL_CYCLES;                         // [RULE1]
                        end
                        fce_pkg::OP_EXT_INDIRECT_CALL: begin
                            next_tgt = {ctx.extended_indirect_reg, ctx.z_ptr}; // [RULE2]
                            cyc      = fce_pkg::CYC_EXTENDED_INDIRECT_CALL;                  // [RULE2]
                        end
                        fce_pkg::OP_COMPARE_SKIP_EQUAL: begin
                            if (ctx.rd_val == ctx.rr_val) begin              // [RULE3]
                                next_tgt = skip_tgt;
                                cyc      = skip_cyc;
                            end
                        end
                        fce_pkg::OP_SKIP_REG_BIT_CLEAR: begin
                            if (!ctx.rd_val[req.bit_sel]) begin              // [RULE4]
                                next_tgt = skip_tgt;
                                cyc      = skip_cyc;
                            end
                        end
                        fce_pkg::OP_SKIP_REG_BIT_SET: begin
                            if (ctx.rd_val[req.bit_sel]) begin               // [RULE5]
                                next_tgt = skip_tgt;
                                cyc      = skip_cyc;
                            end
                        end
                        fce_pkg::OP_SKIP_IO_BIT_CLEAR,
                        fce_pkg::OP_SKIP_IO_BIT_SET: begin
                            // The extra cycle is the I/O read itself.
                            go            = 1'b0;
                            next_state    = fce_pkg::ST_IO;                  // [RULE6] [RULE7]
                            next_ready    = 1'b0;
                            next_io_rd_en = 1'b1;
                            next_io_addr  = req.io_addr;
                        end
                        default: begin
                            if (is_branch && br_cond) begin
                                next_tgt = br_tgt;                           // [RULE8]
                                cyc      = fce_pkg::CYC_TAKEN;
                            end
                        end
                    endcase
                end
            end
            fce_pkg::ST_IO: begin
                go        = 1'b1;
                next_tgt  = pc_q + fce_pkg::STEP_SEQ;
                cyc       = fce_pkg::CYC_SEQ;
                if (io_cond) begin
                    next_tgt = pc_q + (req_q.next_two_word ? fce_pkg::STEP_SKIP2
                                                          : fce_pkg::STEP_SKIP1); // [RULE17]
                    cyc      = req_q.next_two_word ? fce_pkg::CYC_SKIP2
                                                   : fce_pkg::CYC_SKIP1;
                end
            end
            fce_pkg::ST_WAIT: begin
                if (cnt == fce_pkg::CNT_RST) begin
                    next_done    = 1'b1;
                    next_pc_next = tgt;
                    next_ready   = 1'b1;
                    next_state   = fce_pkg::ST_IDLE;
                end else begin
                    next_cnt = cnt - 3'h1;
                end
            end
            default: begin
                next_state = fce_pkg::ST_IDLE;
                next_ready = 1'b1;
            end
        endcase
        // Launch: one remaining cycle answers now, more go to the wait.
        if (go) begin
            if (cyc == fce_pkg::CYC_SEQ) begin
                next_done    = 1'b1;                                     // [RULE18]
                next_pc_next = next_tgt;
                next_ready   = 1'b1;
                next_state   = fce_pkg::ST_IDLE;
            end else begin
                next_cnt   = cyc - 3'h2;
                next_ready = 1'b0;
                next_state = fce_pkg::ST_WAIT;
            end
        end
    end

    // Registers of the sequencer; every output leaves from here.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state    <= fce_pkg::ST_IDLE;
            cnt      <= fce_pkg::CNT_RST;
            tgt      <= fce_pkg::PC_RST;
            pc_next  <= fce_pkg::PC_RST;
            ready    <= 1'b1;
            done     <= 1'b0;
            io_rd_en <= 1'b0;
            io_addr  <= fce_pkg::IO_ADDR_RST;
            req_q    <= '0;
            pc_q     <= fce_pkg::PC_RST;
        end else begin
            state    <= next_state;
            cnt      <= next_cnt;
            tgt      <= next_tgt;
            pc_next  <= next_pc_next;
            ready    <= next_ready;
            done     <= next_done;
            io_rd_en <= next_io_rd_en;
            io_addr  <= next_io_addr;
            req_q    <= next_req_q;
            pc_q     <= next_pc_q;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    indirect_call_target_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE1]
        issue && req.op == fce_pkg::OP_INDIRECT_CALL && INDIRECT_CALL_CYCLES == 3'h2
        |-> ##1 !done ##1 done && pc_next == {6'h00, $past(ctx.z_ptr, 2)})
        else $error("Indirect call target or timing wrong.");

    extended_indirect_call_target_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE2]
        issue && req.op == fce_pkg::OP_EXT_INDIRECT_CALL
        |-> ##1 (!done)[*2] ##1 done
            && pc_next == {$past(ctx.extended_indirect_reg, 3), $past(ctx.z_ptr, 3)})
        else $error("Extended indirect call target or timing wrong.");

    compare_skip_equal_skip_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE3]
        issue && req.op == fce_pkg::OP_COMPARE_SKIP_EQUAL
        && ctx.rd_val == ctx.rr_val && req.next_two_word
        |-> ##3 done && pc_next == $past(ctx.pc, 3) + 22'h000003)
        else $error("Compare skip over two words wrong.");

    reg_clear_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE4]
        issue && req.op == fce_pkg::OP_SKIP_REG_BIT_CLEAR
        && !ctx.rd_val[req.bit_sel] && !req.next_two_word
        |-> ##1 !done ##1 done && pc_next == $past(ctx.pc, 2) + 22'h000002)
        else $error("Register bit clear skip wrong.");

    reg_set_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE5]
        issue && req.op == fce_pkg::OP_SKIP_REG_BIT_SET && !ctx.rd_val[req.bit_sel]
        |-> ##1 done && pc_next == $past(ctx.pc) + 22'h000001)
        else $error("Register bit set skip taken wrongly.");

    io_read_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE6]
        issue && req.op == fce_pkg::OP_SKIP_IO_BIT_CLEAR
        |-> ##1 io_rd_en && io_addr == $past(req.io_addr) && !done && !ready)
        else $error("I/O skip did not read its register.");

    io_noskip_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE7]
        state == fce_pkg::ST_IO && req_q.op == fce_pkg::OP_SKIP_IO_BIT_SET
        && !io_rdata[req_q.bit_sel]
        |-> ##1 done && pc_next == $past(pc_q) + 22'h000001)
        else $error("I/O bit set skip taken wrongly.");

    br_taken_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE8]
        issue && req.op == fce_pkg::OP_BRANCH_FLAG_SET && sf[req.flag_sel]
        |-> ##1 !done ##1 done && pc_next == $past(ctx.pc, 2)
            + {{15{$past(req.offset[6], 2)}}, $past(req.offset, 2)} + 22'h000001)
        else $error("Taken flag branch wrong.");

    br_signed_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE12]
        issue && req.op == fce_pkg::OP_BRANCH_GE_SIGNED
        && (sf[fce_pkg::FLAG_N] ^ sf[fce_pkg::FLAG_V])
        |-> ##1 done && pc_next == $past(ctx.pc) + 22'h000001)
        else $error("Signed branch taken wrongly.");

    br_untaken_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE18]
        issue && is_branch && !br_cond
        |-> ##1 done && ready && pc_next == $past(ctx.pc) + 22'h000001)
        else $error("Untaken branch did not fall through.");

endmodule

`default_nettype wire

// *** dv/cpu_flow_control_exec_bench.sv ***
// Self-checking bench for the flow-control execute unit.
// Assumes fce_pkg is compiled first and fce_exec keeps its default call latency.
`timescale 1ns/10ps
`default_nettype none

module cpu_flow_control_exec_bench;
    // ****************************************************************
    // Signals and operand rows
    // ****************************************************************
    // One row per operation from compare-skip onward: select, operand, mask that undoes it.
    typedef struct packed {
        logic [2:0] sel;
        logic [7:0] a;
        logic [7:0] m;
    } fce_row_t;
    localparam logic [21:0] BASE = 22'h000100;
    logic                   ref_clk = 1'b0;
    logic                   rstn = 1'b0;
    logic                   issue_valid = 1'b0;
    fce_pkg::fce_req_t      req = '0;
    fce_pkg::fce_ctx_t      ctx = '0;
    logic [7:0]             io_rdata = 8'h00;
    logic                   ready, done, io_rd_en;
    logic [21:0]            pc_next;
    logic [5:0]             io_addr, seen_addr;
    int                     miscompares = 0, n_compared = 0, cycles = 0, n_io = 0;
    fce_row_t               rows[25];

    fce_exec i_fce_exec (
        .ref_clk(ref_clk), .rstn(rstn), .issue_valid(issue_valid), .req(req), .ctx(ctx),
        .ready(ready), .done(done), .pc_next(pc_next), .io_rd_en(io_rd_en),
        .io_addr(io_addr), .io_rdata(io_rdata)
    );

    // The clock toggles every half period of 2.5 ns.
    always #2.5 ref_clk = ~ref_clk;

    // Counts I/O reads and bounds the run, because a lost handshake would never end it.
    always @(posedge ref_clk) begin
        cycles++;
        if (io_rd_en === 1'b1) begin
            n_io++;
            seen_addr = io_addr;
        end
        if (cycles >= 3000) begin
            miscompares++;
            end_of_test();
        end
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    // Compares one value and reports a difference at once.
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Issues one instruction and checks latency, target and I/O traffic.
    task automatic run(input fce_pkg::fce_req_t r, input fce_pkg::fce_ctx_t c, input logic [7:0] io,
                       input logic [21:0] pc, input int cyc, input int nio);
        int n = 1; // The taking edge already counts as the first cycle.
        n_io = 0;
        req = r;
        ctx = c;
        io_rdata = io;
        issue_valid = 1'b1;
        @(posedge ref_clk);
        #1;
        // A busy unit is offered a fresh request that it has to ignore.
        // A one-cycle op keeps the strobe up; the next row replaces it before the edge.
        if (cyc > 1) req.op = fce_pkg::OP_NONE;
        check("ready", 32'(ready), 32'(cyc == 1)); // Busy flag
        while (done !== 1'b1 && n < 8) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        check("cycles", 32'(n), 32'(cyc)); // Latency
        check("pc_next", 32'(pc_next), 32'(pc)); // Target
        check("io reads", 32'(n_io), 32'(nio)); // One read
        if (nio > 0) check("io_addr", 32'(seen_addr), 32'(r.io_addr)); // Address
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        fce_pkg::fce_req_t r;
        fce_pkg::fce_ctx_t c;
        logic [7:0]        v;
        logic [21:0]       step;
        logic              sk, io;
        rows = '{'{3'h0, 8'h5A, 8'h01}, '{3'h3, 8'hF7, 8'h08}, '{3'h7, 8'h80, 8'h80},
                 '{3'h2, 8'hFB, 8'h04}, '{3'h1, 8'h02, 8'h02}, '{3'h4, 8'h10, 8'hFF},
                 '{3'h2, 8'hFB, 8'hFF}, '{3'h0, 8'h02, 8'hFF}, '{3'h0, 8'hFD, 8'hFF},
                 '{3'h0, 8'h01, 8'hFF}, '{3'h0, 8'hFE, 8'hFF}, '{3'h0, 8'hFE, 8'hFF},
                 '{3'h0, 8'h01, 8'hFF}, '{3'h0, 8'h04, 8'hFF}, '{3'h0, 8'hFB, 8'hFF},
                 '{3'h0, 8'h0C, 8'h08}, '{3'h0, 8'h08, 8'h04}, '{3'h0, 8'h20, 8'hFF},
                 '{3'h0, 8'hDF, 8'hFF}, '{3'h0, 8'h40, 8'hFF}, '{3'h0, 8'hBF, 8'hFF},
                 '{3'h0, 8'h08, 8'hFF}, '{3'h0, 8'hF7, 8'hFF}, '{3'h0, 8'h80, 8'hFF},
                 '{3'h0, 8'h7F, 8'hFF}};
        repeat (8) @(posedge ref_clk);
        #1;
        check("reset", 32'({ready, done, io_rd_en, io_addr, pc_next}), 32'({3'b100, 28'h0}));
        rstn = 1'b1;
        // Pass bit 0 undoes the condition, pass bit 1 makes the following instruction two words.
        for (int p = 0; p < 4; p++) begin
            for (int i = 0; i < 25; i++) begin
                v = p[0] ? rows[i].a ^ rows[i].m : rows[i].a;
                r = '0;
                r.op = fce_pkg::fce_op_t'(5'(i + 3));
                r.flag_sel = rows[i].sel;
                r.bit_sel = rows[i].sel;
                r.offset = i[0] ? 7'h40 : 7'h3F;
                r.io_addr = 6'(i + 1);
                r.next_two_word = p[1];
                c = '0;
                c.pc = BASE;
                c.z_ptr = 16'hFFFF;
                c.status_flags = v;
                c.rd_val = v;
                c.rr_val = (i == 0) ? rows[i].a : v;
                sk = (i < 5);
                io = (i == 3 || i == 4);
                step = sk ? (p[1] ? 22'h000003 : 22'h000002) : {{15{r.offset[6]}}, r.offset} + 22'h1;
                run(r, c, io ? v : ~v, p[0] ? BASE + 22'h1 : BASE + step,
                    (p[0] ? 1 : (sk ? int'(step) : 2)) + int'(io), int'(io));
            end
            $display("test operand sweep %0d done", p);
        end
        // Calls: the plain one clears the top bits, the extended one takes them from the register.
        r = '0;
        c = '0;
        c.pc = 22'h3F0000;
        c.z_ptr = 16'hBEEF;
        c.extended_indirect_reg = 6'h2A;
        r.op = fce_pkg::OP_INDIRECT_CALL;
        run(r, c, 8'h00, 22'h00BEEF, 2, 0); // Indirect call
        r.op = fce_pkg::OP_EXT_INDIRECT_CALL;
        run(r, c, 8'h00, 22'h2ABEEF, 3, 0); // Extended call
        // A backward branch near address zero wraps round the top.
        r.op = fce_pkg::OP_BRANCH_EQUAL;
        r.offset = 7'h40;
        c.pc = 22'h000010;
        c.status_flags = 8'h02;
        run(r, c, 8'h00, 22'h3FFFD1, 2, 0); // Wrapped target
        $display("test calls and wrap done");
        // Two untaken branches back to back, each answered one cycle later.
        issue_valid = 1'b1;
        req.op = fce_pkg::OP_BRANCH_NOT_EQUAL;
        @(posedge ref_clk);
        #1;
        ctx.pc = 22'h000300;
        check("first", 32'({done, pc_next}), 32'({1'b1, 22'h000011})); // Sequential
        @(posedge ref_clk);
        #1;
        issue_valid = 1'b0;
        check("second", 32'({done, pc_next}), 32'({1'b1, 22'h000301})); // Sequential
        @(posedge ref_clk);
        #1;
        check("done pulse", 32'(done), 32'(1'b0)); // One-cycle answer
        $display("test back to back done");
        // A reset in the middle of a call drops it; the next call runs clean.
        r.op = fce_pkg::OP_EXT_INDIRECT_CALL;
        req = r;
        issue_valid = 1'b1;
        @(posedge ref_clk);
        #1;
        rstn = 1'b0;
        issue_valid = 1'b0;
        #1;
        check("mid reset", 32'({ready, done, io_rd_en, pc_next}), 32'({3'b100, 22'h0}));
        @(posedge ref_clk);
        #1;
        rstn = 1'b1;
        run(r, c, 8'h00, 22'h2ABEEF, 3, 0); // Call after reset
        $display("test reset in flight done");
        end_of_test();
    end
endmodule
`default_nettype wire
